// ---- hdl/thpg_config.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "thpg_consts.svh"

module thpg_config #(
  parameter int         N_CH       = 4,                     // Monitored channels
  parameter int         GOOD_DELAY = `THPG_GOOD_DELAY_CYC,  // Validation cycles
  parameter logic [6:0] DEV_ADDR   = 7'h2a                  // Arbitrary bus address
) (
  input  wire logic            ref_clk,                 // 200 MHz clock
  input  wire logic            rst_b,                   // Async reset, low
  input  wire logic            scl_in,                  // Bus clock pin
  input  wire logic            sda_in,                  // Bus data pin level
  output var  logic            sda_oe,                  // Data pin pull-down
  input  wire logic [7:0]      die_temp_c,              // Die temp, deg C, on-chip
  input  wire logic [7:0]      supply_dv,               // Supply, 0.1 V units, on-chip
  input  wire logic [N_CH-1:0] channel_good_in,         // Channel good pins
  input  wire logic [N_CH-1:0] channel_enable_inputs,   // Channel enable pins
  input  wire logic            fuse_retry_disable,      // Factory fuse, all channels
  input  wire logic            fuse_good_include,       // Factory fuse, all channels
  output var  logic            sync_pin_output,         // Sync pin drives clock
  output var  logic [N_CH-1:0] retry_protect_enable,    // Hiccup per channel
  output var  logic [N_CH-1:0] short_protect_enable,    // Short-circuit per channel
  output var  logic            overheat_warn,           // Temperature over limit
  output var  logic            low_supply_warn,         // Supply under limit
  output var  logic            combined_good_output,    // Validated good pin
  output var  logic            int_b                    // Interrupt, low active
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [N_CH-1:0] good_meta, good_s, en_meta, en_s;
  logic [N_CH-1:0] good_q;

  // Second stage is the only reader of the first
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      good_meta <= '0;
      good_s    <= '0;
      en_meta   <= '0;
      en_s      <= '0;
      good_q    <= '0;
    end else begin
      good_meta <= channel_good_in;
      good_s    <= good_meta;
      en_meta   <= channel_enable_inputs;
      en_s      <= en_meta;
      good_q    <= good_s;
    end
  end

  // ----------------------------------------------------------------
  // Serial register access
  // ----------------------------------------------------------------
  logic                 wr_stb;
  thpg_pkg::thpg_byte_t wr_addr, wr_data, rd_addr, rd_data;

  thpg_serial_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_slave (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_oe  (sda_oe),
    .wr_stb  (wr_stb),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  thpg_pkg::thpg_byte_t warning_threshold_config, next_warning_threshold_config;
  thpg_pkg::thpg_byte_t hiccup_and_sync_config, next_hiccup_and_sync_config;
  thpg_pkg::thpg_byte_t power_good_channel_mask, next_power_good_channel_mask;
  thpg_pkg::thpg_byte_t event_mask, next_event_mask;
  logic                 fuse_loaded, next_fuse_loaded;

  // Fuses are caught one cycle after release; a host write before that is ignored
  always_comb begin
    next_warning_threshold_config = warning_threshold_config;
    next_hiccup_and_sync_config   = hiccup_and_sync_config;
    next_power_good_channel_mask  = power_good_channel_mask;
    next_event_mask               = event_mask;
    next_fuse_loaded              = 1'b1;
    if (!fuse_loaded) begin
      next_hiccup_and_sync_config[N_CH-1:0]  = {N_CH{fuse_retry_disable}};
      next_power_good_channel_mask[N_CH-1:0] = {N_CH{fuse_good_include}};
    end else if (wr_stb) begin
      unique case (wr_addr)
        `THPG_OFS_WARN_THRESH:  next_warning_threshold_config = wr_data;
        `THPG_OFS_HICCUP_SYNC:  next_hiccup_and_sync_config   = wr_data;
        `THPG_OFS_GOOD_MASK:    next_power_good_channel_mask  = wr_data;
        `THPG_OFS_EVENT_MASK:   next_event_mask               = wr_data;
        default:                next_event_mask               = event_mask;
      endcase
    end
  end

  // Configuration flops
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      warning_threshold_config <= `THPG_RST_WARN_THRESH;
      hiccup_and_sync_config   <= `THPG_RST_HICCUP_SYNC;
      power_good_channel_mask  <= `THPG_RST_GOOD_MASK;
      event_mask               <= `THPG_RST_EVENT_MASK;
      fuse_loaded              <= 1'b0;
    end else begin
      warning_threshold_config <= next_warning_threshold_config;
      hiccup_and_sync_config   <= next_hiccup_and_sync_config;
      power_good_channel_mask  <= next_power_good_channel_mask;
      event_mask               <= next_event_mask;
      fuse_loaded              <= next_fuse_loaded;
    end
  end

  // ----------------------------------------------------------------
  // Threshold decode and compare
  // ----------------------------------------------------------------
  logic [1:0] overheat_threshold_sel;
  logic [3:0] low_supply_threshold_sel;
  logic [7:0] temp_limit_c, supply_limit_dv;
  logic       temp_on, supply_on, temp_over, supply_under;

  assign overheat_threshold_sel   = warning_threshold_config[`THPG_TEMP_SEL_MSB:`THPG_TEMP_SEL_LSB];
  assign low_supply_threshold_sel = warning_threshold_config[`THPG_VIN_SEL_MSB:`THPG_VIN_SEL_LSB];

  // Limit tables; code zero of the temperature field means off
  always_comb begin
    unique case (overheat_threshold_sel)
      2'h1:    temp_limit_c = `THPG_TEMP_LIM_1;
      2'h2:    temp_limit_c = `THPG_TEMP_LIM_2;
      2'h3:    temp_limit_c = `THPG_TEMP_LIM_3;
      default: temp_limit_c = 8'hff;
    endcase
    supply_limit_dv = `THPG_VIN_BASE_DV
                    + 8'({4'h0, low_supply_threshold_sel} * `THPG_VIN_STEP_DV);
  end

  assign temp_on      = (overheat_threshold_sel != `THPG_TEMP_OFF);
  assign supply_on    = (low_supply_threshold_sel != `THPG_VIN_OFF);
  assign temp_over    = temp_on & (die_temp_c > temp_limit_c);
  assign supply_under = supply_on & (supply_dv < supply_limit_dv);

  // ----------------------------------------------------------------
  // Sticky event flags
  // ----------------------------------------------------------------
  logic [N_CH-1:0] good_include, good_fail;
  logic            overheat_event_flag, next_overheat_event_flag;
  logic            low_supply_event_flag, next_low_supply_event_flag;
  logic [N_CH-1:0] good_fail_flag, next_good_fail_flag;
  logic            host_clear, all_off;
  thpg_pkg::thpg_byte_t event_status;

  assign good_include = power_good_channel_mask[N_CH-1:0];
  // Falling good only counts while enabled, so shutdown raises nothing
  assign good_fail    = good_q & ~good_s & en_s;
  assign host_clear   = wr_stb & fuse_loaded & (wr_addr == `THPG_OFS_EVENT_STATUS);
  assign all_off      = (en_s == '0);

  // Write one clears; a new event in the same cycle wins
  always_comb begin
    next_overheat_event_flag   = overheat_event_flag;
    next_low_supply_event_flag = low_supply_event_flag;
    next_good_fail_flag        = good_fail_flag;
    if (all_off) begin
      next_overheat_event_flag   = 1'b0;
      next_low_supply_event_flag = 1'b0;
      next_good_fail_flag        = '0;
    end else if (host_clear) begin
      next_overheat_event_flag   = overheat_event_flag & ~wr_data[`THPG_EVT_TEMP_BIT];
      next_low_supply_event_flag = low_supply_event_flag & ~wr_data[`THPG_EVT_VIN_BIT];
      next_good_fail_flag        = good_fail_flag & ~wr_data[N_CH-1:0];
    end
    next_overheat_event_flag   = next_overheat_event_flag | temp_over;
    next_low_supply_event_flag = next_low_supply_event_flag | supply_under;
    next_good_fail_flag        = next_good_fail_flag | good_fail;
  end

  // Flag flops
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      overheat_event_flag   <= 1'b0;
      low_supply_event_flag <= 1'b0;
      good_fail_flag        <= '0;
    end else begin
      overheat_event_flag   <= next_overheat_event_flag;
      low_supply_event_flag <= next_low_supply_event_flag;
      good_fail_flag        <= next_good_fail_flag;
    end
  end

  always_comb begin
    event_status                    = 8'h00;
    event_status[`THPG_EVT_TEMP_BIT] = overheat_event_flag;
    event_status[`THPG_EVT_VIN_BIT]  = low_supply_event_flag;
    event_status[N_CH-1:0]          = good_fail_flag;
  end

  // ----------------------------------------------------------------
  // Good validation delay
  // ----------------------------------------------------------------
  localparam int CW = $clog2(GOOD_DELAY + 1);
  logic [CW-1:0] good_cnt, next_good_cnt;
  logic          all_good, next_combined_good;

  assign all_good = &(good_s | ~good_include);

  // Any included failure drops the pin and restarts the count
  always_comb begin
    next_good_cnt      = good_cnt;
    next_combined_good = combined_good_output;
    if (!all_good) begin
      next_good_cnt      = '0;
      next_combined_good = 1'b0;
    end else if (good_cnt < CW'(GOOD_DELAY - 1)) begin
      next_good_cnt = good_cnt + CW'(1);
    end else begin
      next_combined_good = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Outputs and read mux
  // ----------------------------------------------------------------
  logic            next_int_b, next_sync_out;
  logic [N_CH-1:0] next_retry_en;

  assign next_int_b    = ~|(event_status & ~event_mask);
  assign next_sync_out = hiccup_and_sync_config[`THPG_SYNC_OUT_BIT];
  assign next_retry_en = ~hiccup_and_sync_config[N_CH-1:0];

  // Every output is a flop for clean pin timing
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      good_cnt             <= '0;
      combined_good_output <= 1'b0;
      int_b                <= 1'b1;
      sync_pin_output      <= 1'b0;
      retry_protect_enable <= '0;
      short_protect_enable <= '0;
      overheat_warn        <= 1'b0;
      low_supply_warn      <= 1'b0;
    end else begin
      good_cnt             <= next_good_cnt;
      combined_good_output <= next_combined_good;
      int_b                <= next_int_b;
      sync_pin_output      <= next_sync_out;
      retry_protect_enable <= next_retry_en;
      short_protect_enable <= next_retry_en;
      overheat_warn        <= temp_over;
      low_supply_warn      <= supply_under;
    end
  end

  // Unmapped offsets read as zero
  always_comb begin
    unique case (rd_addr)
      `THPG_OFS_WARN_THRESH:  rd_data = warning_threshold_config;
      `THPG_OFS_HICCUP_SYNC:  rd_data = hiccup_and_sync_config;
      `THPG_OFS_GOOD_MASK:    rd_data = power_good_channel_mask;
      `THPG_OFS_GOOD_STATUS:  rd_data = 8'({good_s});
      `THPG_OFS_EVENT_STATUS: rd_data = event_status;
      `THPG_OFS_EVENT_MASK:   rd_data = event_mask;
      default:                rd_data = 8'h00;
    endcase
  end

endmodule // thpg_config

`default_nettype wire

// ---- hdl/thpg_consts.svh ----
`ifndef THPG_CONSTS_SVH
`define THPG_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define THPG_OFS_WARN_THRESH   8'h09
`define THPG_OFS_HICCUP_SYNC   8'h0a
`define THPG_OFS_GOOD_MASK     8'h0b
`define THPG_OFS_GOOD_STATUS   8'h0d
`define THPG_OFS_EVENT_STATUS  8'h0e
`define THPG_OFS_EVENT_MASK    8'h0f

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define THPG_TEMP_SEL_MSB      5
`define THPG_TEMP_SEL_LSB      4
`define THPG_VIN_SEL_MSB       3
`define THPG_VIN_SEL_LSB       0
`define THPG_SYNC_OUT_BIT      7
`define THPG_EVT_TEMP_BIT      5
`define THPG_EVT_VIN_BIT       4

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define THPG_RST_WARN_THRESH   8'h00
`define THPG_RST_HICCUP_SYNC   8'h00
`define THPG_RST_GOOD_MASK     8'h00
`define THPG_RST_EVENT_MASK    8'h00
`define THPG_TEMP_OFF          2'h0
`define THPG_VIN_OFF           4'hf
`define THPG_TEMP_LIM_1        8'h69
`define THPG_TEMP_LIM_2        8'h73
`define THPG_TEMP_LIM_3        8'h7d
`define THPG_VIN_BASE_DV       8'h2a
`define THPG_VIN_STEP_DV       8'h05

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define THPG_CLK_MHZ           200
`define THPG_GOOD_DELAY_US     1000
`define THPG_GOOD_DELAY_CYC    (`THPG_GOOD_DELAY_US * `THPG_CLK_MHZ)

`endif

// ---- hdl/thpg_pkg.sv ----
package thpg_pkg;

  // Serial slave sequencing
  typedef enum logic [3:0] {
    THPG_SER_IDLE,
    THPG_SER_ADDR,
    THPG_SER_ADDR_ACK,
    THPG_SER_PTR,
    THPG_SER_PTR_ACK,
    THPG_SER_WDATA,
    THPG_SER_WDATA_ACK,
    THPG_SER_RDATA,
    THPG_SER_RDATA_ACK
  } thpg_ser_e;

  typedef logic [7:0] thpg_byte_t;

endpackage

// ---- hdl/thpg_serial_slave.sv ----
`timescale 1ns/1ps
`default_nettype none

module thpg_serial_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h2a  // Arbitrary bus address
) (
  input  wire logic              ref_clk,     // System clock
  input  wire logic              rst_b,       // Async reset, low
  input  wire logic              scl_in,      // Bus clock pin level
  input  wire logic              sda_in,      // Bus data pin level
  output var  logic              sda_oe,      // High pulls data low
  output var  logic              wr_stb,      // One-cycle write strobe
  output var  thpg_pkg::thpg_byte_t wr_addr,  // Write register offset
  output var  thpg_pkg::thpg_byte_t wr_data,  // Write data
  output var  thpg_pkg::thpg_byte_t rd_addr,  // Read register offset
  input  wire thpg_pkg::thpg_byte_t rd_data   // Read data, same cycle
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] scl_meta, sda_meta;
  logic       scl_q, sda_q;
  logic       scl_s, sda_s;

  // Stage one feeds stage two only; edges come from later stages
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_meta <= 2'h3;
      sda_meta <= 2'h3;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else begin
      scl_meta <= {scl_meta[0], scl_in};
      sda_meta <= {sda_meta[0], sda_in};
      scl_q    <= scl_meta[1];
      sda_q    <= sda_meta[1];
    end
  end
  assign scl_s = scl_meta[1];
  assign sda_s = sda_meta[1];

  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_c  = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_c   = scl_s & scl_q & ~sda_q & sda_s;

  // ----------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------
  thpg_pkg::thpg_ser_e  state, next_state;
  logic [3:0]           bit_cnt, next_bit_cnt;
  thpg_pkg::thpg_byte_t shift, next_shift;
  thpg_pkg::thpg_byte_t ptr, next_ptr;
  thpg_pkg::thpg_byte_t next_wr_data;
  logic                 rw, next_rw;
  logic                 next_sda_oe, next_wr_stb;

  // Sample on rising clock, drive on falling clock
  always_comb begin
    next_state   = state;
    next_bit_cnt = bit_cnt;
    next_shift   = shift;
    next_ptr     = ptr;
    next_rw      = rw;
    next_sda_oe  = sda_oe;
    next_wr_stb  = 1'b0;
    next_wr_data = wr_data;
    if (start_c) begin
      next_state   = thpg_pkg::THPG_SER_ADDR;
      next_bit_cnt = 4'h0;
      next_sda_oe  = 1'b0;
    end else if (stop_c) begin
      next_state  = thpg_pkg::THPG_SER_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      unique case (state)
        thpg_pkg::THPG_SER_IDLE: begin
          next_sda_oe = 1'b0;
        end
        thpg_pkg::THPG_SER_ADDR, thpg_pkg::THPG_SER_PTR, thpg_pkg::THPG_SER_WDATA: begin
          if (scl_rise) begin
            next_shift   = {shift[6:0], sda_s};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            next_sda_oe = 1'b1;
            if (state == thpg_pkg::THPG_SER_ADDR) begin
              next_rw    = shift[0];
              next_state = thpg_pkg::THPG_SER_ADDR_ACK;
              // Foreign address: stay silent until the next start
              if (shift[7:1] != DEV_ADDR) begin
                next_sda_oe = 1'b0;
                next_state  = thpg_pkg::THPG_SER_IDLE;
              end
            end else if (state == thpg_pkg::THPG_SER_PTR) begin
              next_ptr   = shift;
              next_state = thpg_pkg::THPG_SER_PTR_ACK;
            end else begin
              next_wr_stb  = 1'b1;
              next_wr_data = shift;
              next_state   = thpg_pkg::THPG_SER_WDATA_ACK;
            end
          end
        end
        thpg_pkg::THPG_SER_ADDR_ACK, thpg_pkg::THPG_SER_PTR_ACK, thpg_pkg::THPG_SER_WDATA_ACK: begin
          if (scl_fall) begin
            next_sda_oe  = 1'b0;
            next_bit_cnt = 4'h0;
            if (state == thpg_pkg::THPG_SER_ADDR_ACK && rw) begin
              // Read starts at the current pointer, then auto-increments
              next_shift  = rd_data;
              next_sda_oe = ~rd_data[7];
              next_ptr    = ptr + 8'h01;
              next_state  = thpg_pkg::THPG_SER_RDATA;
            end else if (state == thpg_pkg::THPG_SER_ADDR_ACK) begin
              next_state = thpg_pkg::THPG_SER_PTR;
            end else begin
              if (state == thpg_pkg::THPG_SER_WDATA_ACK) begin
                next_ptr = ptr + 8'h01;
              end
              next_state = thpg_pkg::THPG_SER_WDATA;
            end
          end
        end
        thpg_pkg::THPG_SER_RDATA: begin
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              next_sda_oe = 1'b0;
              next_state  = thpg_pkg::THPG_SER_RDATA_ACK;
            end else begin
              next_shift  = {shift[6:0], 1'b0};
              next_sda_oe = ~shift[6];
            end
          end
        end
        thpg_pkg::THPG_SER_RDATA_ACK: begin
          if (scl_rise && sda_s) begin
            next_state = thpg_pkg::THPG_SER_IDLE;
          end else if (scl_fall) begin
            next_bit_cnt = 4'h0;
            next_shift   = rd_data;
            next_sda_oe  = ~rd_data[7];
            next_ptr     = ptr + 8'h01;
            next_state   = thpg_pkg::THPG_SER_RDATA;
          end
        end
      endcase
    end
  end

  // Engine registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state   <= thpg_pkg::THPG_SER_IDLE;
      bit_cnt <= 4'h0;
      shift   <= 8'h00;
      ptr     <= 8'h00;
      rw      <= 1'b0;
      sda_oe  <= 1'b0;
      wr_stb  <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      state   <= next_state;
      bit_cnt <= next_bit_cnt;
      shift   <= next_shift;
      ptr     <= next_ptr;
      rw      <= next_rw;
      sda_oe  <= next_sda_oe;
      wr_stb  <= next_wr_stb;
      wr_data <= next_wr_data;
    end
  end

  assign wr_addr = ptr;
  assign rd_addr = ptr;

endmodule // thpg_serial_slave

`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {logic [7:0] a, v, t, s; logic [6:0] e;} thpg_row_s;
  logic       ref_clk = 0, rst_b = 0, fuse = 1, h_scl, h_oe, sda_oe, sync, ovh, low, good, int_b;
  logic [7:0] temp = 0, vin = 8'h64, d;
  logic [3:0] cg = 4'hf, en = 4'hf, retry;
  int         n_errors = 0, n_checks = 0;
  wire logic  sda;
  // Offset, data, temp, supply -> sync, retry, warnings
  thpg_row_s rows [8] = '{{8'h09, 8'hd0, 8'h6a, 8'h2a, 7'h02}, {8'h09, 8'h10, 8'h69, 8'h29, 7'h01},
    {8'h09, 8'h2e, 8'h74, 8'h6f, 7'h03}, {8'h09, 8'h3e, 8'h7d, 8'h70, 7'h00},
    {8'h09, 8'h3f, 8'h7e, 8'h00, 7'h02}, {8'h09, 8'h0f, 8'hc8, 8'h00, 7'h00},
    {8'h0a, 8'hf5, 8'hc8, 8'h00, 7'h68}, {8'h0a, 8'h0a, 8'hc8, 8'h00, 7'h14}};
  // Pull-up data wire
  assign sda = !(h_oe || sda_oe);
  always #2.5 ref_clk = !ref_clk;
  thpg_host u_thpg_host (.ref_clk(ref_clk), .sda_in(sda), .scl(h_scl), .sda_oe(h_oe));
  thpg_config #(.GOOD_DELAY(20)) u_thpg_config (.ref_clk(ref_clk), .rst_b(rst_b), .scl_in(h_scl),
    .sda_in(sda), .sda_oe(sda_oe), .die_temp_c(temp), .supply_dv(vin), .channel_good_in(cg),
    .channel_enable_inputs(en), .fuse_retry_disable(fuse), .fuse_good_include(fuse),
    .sync_pin_output(sync), .retry_protect_enable(retry), .short_protect_enable(),
    .overheat_warn(ovh), .low_supply_warn(low), .combined_good_output(good), .int_b(int_b));
  task automatic chk(input string nm, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic nap(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence, inputs move on falling edges
  initial begin
    nap(16); rst_b = 1;
    foreach (rows[i]) begin
      temp = rows[i].t; vin = rows[i].s; u_thpg_host.wr(rows[i].a, rows[i].v); nap(8);
      chk("outputs", {1'b0, rows[i].e}, {1'b0, sync, retry, ovh, low});
      u_thpg_host.rd(rows[i].a, d);
      chk("readback", rows[i].v, d);
    end
    $display("config rows done");
    vin = 8'h64; rst_b = 0; nap(16); rst_b = 1; nap(4);
    chk("reset pins", 8'h01, {sync, retry, ovh, low, int_b});
    u_thpg_host.rd(8'h0a, d);
    chk("retry reset", 8'h0f, d);
    u_thpg_host.rd(8'h0b, d);
    chk("include reset", 8'h0f, d);
    $display("reset test done");
    chk("good high", 8'h01, {7'h0, good});
    cg = 4'hb; nap(6);
    chk("good drop", 8'h00, {7'h0, good});
    cg = 4'hf; nap(10); cg = 4'he; nap(3); cg = 4'hf; nap(15);
    chk("good restart", 8'h00, {7'h0, good});
    nap(15);
    chk("good back", 8'h01, {7'h0, good});
    u_thpg_host.wr(8'h0b, 8'h0b); cg = 4'hb; nap(6);
    chk("masked drop", 8'h01, {7'h0, good});
    $display("good pin test done");
    chk("int held", 8'h00, {7'h0, int_b});
    u_thpg_host.wr(8'h0e, 8'hff); nap(4);
    chk("int cleared", 8'h01, {7'h0, int_b});
    u_thpg_host.wr(8'h09, 8'h10); u_thpg_host.wr(8'h09, 8'h00);
    chk("int on event", 8'h00, {7'h0, int_b});
    en = 4'h0; nap(8); en = 4'hf; nap(8);
    chk("int by enables", 8'h01, {7'h0, int_b});
    $display("interrupt test done");
    fuse = 0; rst_b = 0; nap(4); rst_b = 1; nap(24);
    chk("fuse off", 8'h79, {sync, retry, ovh, low, int_b});
    chk("fuse good", 8'h01, {7'h0, good});
    $display("fuse test done");
    give_verdict();
  end
  // Cut a hang short, run needs about 18000 cycles
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_errors++;
    give_verdict();
  end
endmodule // tb
`default_nettype wire

// ---- verification/thpg_config_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module thpg_config_chk #(
  parameter int N_CH       = 4,   // Channels
  parameter int GOOD_DELAY = 20   // Validation cycles
) (
  input wire logic            ref_clk,               // Clock
  input wire logic            rst_b,                 // Reset, low
  input wire logic            scl_in,                // Bus clock
  input wire logic [7:0]      die_temp_c,            // Die temp
  input wire logic [7:0]      supply_dv,             // Supply
  input wire logic [N_CH-1:0] channel_good_in,       // Good pins
  input wire logic [N_CH-1:0] channel_enable_inputs, // Enables
  input wire logic            sync_pin_output,       // Sync dir
  input wire logic [N_CH-1:0] retry_protect_enable,  // Retry on
  input wire logic [N_CH-1:0] short_protect_enable,  // Short on
  input wire logic            overheat_warn,         // Temp warn
  input wire logic            low_supply_warn,       // Supply warn
  input wire logic            combined_good_output,  // Good pin
  input wire logic            int_b                  // Interrupt
);
  int   low_n, quiet, good_n, next_low_n, next_quiet, next_good_n;
  logic last_scl;
  // Pin low time, bus quiet time, all-good time
  always_comb begin
    next_low_n  = combined_good_output ? 0 : low_n + 1;
    next_quiet  = (scl_in != last_scl || channel_enable_inputs == '0) ? 0 : quiet + 1;
    next_good_n = &channel_good_in ? good_n + 1 : 0;
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_n <= 0; quiet <= 0; good_n <= 0; last_scl <= 1'b1;
    end else begin
      low_n <= next_low_n; quiet <= next_quiet; good_n <= next_good_n; last_scl <= scl_in;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  short_follow_a: assert property (short_protect_enable == retry_protect_enable)
    else $error("short enables differ from retry enables");
  good_delay_a: assert property ($rose(combined_good_output) |-> low_n >= GOOD_DELAY)
    else $error("good pin rose early");
  good_hold_a: assert property (combined_good_output && good_n > 4 |=> combined_good_output)
    else $error("good pin fell with all good");
  temp_warn_a: assert property (overheat_warn |-> $past(die_temp_c) > 8'h69 || $past(die_temp_c, 2) > 8'h69)
    else $error("overheat warning below limit");
  supply_warn_a: assert property (low_supply_warn |-> $past(supply_dv) < 8'h70 || $past(supply_dv, 2) < 8'h70)
    else $error("supply warning above limit");
  warn_int_a: assert property (overheat_warn || low_supply_warn |-> ##[0:2] !int_b)
    else $error("warning without interrupt");
  int_sticky_a: assert property (!int_b && quiet > 12 |=> !int_b)
    else $error("interrupt cleared itself");
  cfg_bus_a: assert property ($changed({sync_pin_output, retry_protect_enable}) |-> quiet < 12)
    else $error("config changed without a bus write");
endmodule // thpg_config_chk
bind thpg_config thpg_config_chk #(.N_CH(N_CH), .GOOD_DELAY(GOOD_DELAY)) u_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .scl_in(scl_in), .die_temp_c(die_temp_c),
  .supply_dv(supply_dv), .channel_good_in(channel_good_in),
  .channel_enable_inputs(channel_enable_inputs), .sync_pin_output(sync_pin_output),
  .retry_protect_enable(retry_protect_enable), .short_protect_enable(short_protect_enable),
  .overheat_warn(overheat_warn), .low_supply_warn(low_supply_warn),
  .combined_good_output(combined_good_output), .int_b(int_b));
`default_nettype wire

// ---- verification/thpg_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// Bus master, eight-clock steps; bus clock low for two steps, high for one
module thpg_host #(
  parameter logic [6:0] DEV_ADDR = 7'h2a  // Arbitrary bus address
) (
  input  wire logic ref_clk,  // System clock
  input  wire logic sda_in,   // Resolved data wire
  output var  logic scl,      // Bus clock, idles high
  output var  logic sda_oe    // High pulls data low
);
  logic [8:0] r;              // Bits seen in last byte
  // Idle with both wires released
  initial begin
    scl = 1;
    sda_oe = 0;
  end
  task automatic ph();
    repeat (8) @(negedge ref_clk);
  endtask
  // Start, also used as repeated start
  task automatic st();
    sda_oe = 0; ph(); scl = 1; ph(); sda_oe = 1; ph(); scl = 0;
  endtask
  // Data moves mid low phase, clear of start detection
  task automatic bt(input logic [8:0] v);
    for (int i = 8; i >= 0; i--) begin
      ph(); sda_oe = !v[i]; ph(); scl = 1; ph(); r[i] = sda_in; scl = 0;
    end
  endtask
  task automatic sp();
    ph(); sda_oe = 1; ph(); scl = 1; ph(); sda_oe = 0; ph();
  endtask
  task automatic wr(input logic [7:0] a, d);
    st(); bt({DEV_ADDR, 2'b01}); bt({a, 1'b1}); bt({d, 1'b1}); sp();
  endtask
  // Read one byte, then refuse more
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    st(); bt({DEV_ADDR, 2'b01}); bt({a, 1'b1}); st(); bt({DEV_ADDR, 2'b11});
    bt(9'h1ff); d = r[8:1]; sp();
  endtask
endmodule // thpg_host
`default_nettype wire
